// [hw/icm_pkg.sv]
`default_nettype none
package icm_pkg;
    // System clock period
    localparam int unsigned CLK_PERIOD_NS   = 20;
    // Minimum reset pin low width; plain default, tune per process
    localparam int unsigned RST_PULSE_NS    = 500;
    localparam int unsigned RST_PULSE_CYC   =
        (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Widest supply glitch that must be ridden through
    localparam int unsigned GLITCH_US       = 10;
    localparam int unsigned GLITCH_CYC      =
        (GLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Supply detector thresholds, set in the analogue comparator
    localparam int unsigned POR_FALL_MIN_MV = 700;
    localparam int unsigned POR_RISE_MAX_MV = 1500;
    // Supply dip the system must apply to force a full reset
    localparam int unsigned FORCE_MARGIN_MV = 50;
    localparam int unsigned FORCE_FLOOR_MV  = 200;
    localparam int unsigned FORCE_HOLD_US   = 1;
    // Control byte fields and reset value
    localparam int unsigned CTRL_EN_POS     = 3;
    localparam int unsigned CTRL_IDX_LSB    = 0;
    localparam int unsigned CTRL_IDX_W      = 3;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    // Reserved addresses, the software reset code and the byte length
    localparam logic [7:0]  GC_ADDR_WR      = 8'h00;
    localparam logic [7:0]  SWRST_CODE      = 8'h06;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_GC, ST_RD, ST_RDACK, ST_IGN
    } icm_state_t;

    // Whole state of the selector
    typedef struct packed {
        icm_state_t  st;     // Current bus phase
        icm_state_t  nxt;    // Phase after the acknowledge bit
        logic        scl_q;  // Previous clock line level
        logic        sda_q;  // Previous data line level
        logic [3:0]  cnt;    // Bit counter within a byte
        logic [7:0]  sh;     // Shift register
        logic        sda_oe; // Pull data line low
        logic [7:0]  ctrl;   // channel_select register
        logic [7:0]  pend;   // Byte waiting for STOP
        logic        pend_v; // Pending byte is valid
        logic        gc_arm; // Software reset armed
        logic [7:0]  chan;   // One-hot channel connections
    } icm_regs_t;

    localparam icm_regs_t REGS_RESET = '{
        st: ST_IDLE, nxt: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1,
        cnt: 4'h0, sh: 8'h00, sda_oe: 1'b0, ctrl: CTRL_RESET,
        pend: 8'h00, pend_v: 1'b0, gc_arm: 1'b0, chan: 8'h00};
endpackage
`default_nettype wire

// [hw/icm_hold_filter.sv]
`default_nettype none
// Raises its output once the input has stood high for CYC cycles;
// drops it the cycle after the input falls
module icm_hold_filter #(
    parameter int unsigned CYC = 16
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic level_in,
    output var  logic trip_out
);
    typedef struct packed {
        logic [15:0] cnt;  // Cycles the input has been high
        logic        trip; // Held long enough
    } icm_filt_t;

    localparam logic [15:0] LAST = 16'(CYC - 1);

    icm_filt_t r, n;

    // Count a sustained level; any drop restarts the count
    always_comb begin
        n = r;
        if (!level_in) begin
            n.cnt  = 16'h0000;
            n.trip = 1'b0;
        end else if (r.cnt >= LAST) begin
            n.trip = 1'b1;
        end else begin
            n.cnt = r.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign trip_out = r.trip;
endmodule
`default_nettype wire

// [hw/icm_mux_ctrl.sv]
`default_nettype none
// Channel selector of an eight-way bus switch, with its reset sources
module icm_mux_ctrl
    import icm_pkg::*;
(
    input  wire logic       CLK_SYS_IN,        // 50 MHz system clock
    input  wire logic       RST_IN,            // Async reset, active high
    input  wire logic       RESET_N_IN,        // Reset pin, active low
    input  wire logic       SUPPLY_LOW_IN,     // Core supply under trip
    input  wire logic [6:0] SLAVE_ADDR_IN,     // Strapped slave address
    input  wire logic       SCL_IN,            // Upstream clock line
    input  wire logic       SDA_IN,            // Upstream data line
    output var  logic       SDA_OUT,           // Data drive value
    output var  logic       SDA_OE_OUT,        // Data pulled low
    output var  logic [7:0] CHAN_EN_OUT        // Downstream pair enables
);
    icm_regs_t r, n;       // Registered state and its next value
    logic      rst_trip;   // Reset pin held low long enough
    logic      por_trip;   // Supply low long enough
    logic      dev_rst;    // Any internal reset source
    logic      rise_w;     // Clock line rising
    logic      fall_w;     // Clock line falling
    logic      start_w;    // START or repeated START
    logic      stop_w;     // STOP

    // One-hot connection pattern for a control byte
    function automatic logic [7:0] chan_decode(input logic [7:0] b);
        logic [7:0] oh;
        oh = 8'h00;
        if (b[CTRL_EN_POS]) begin
            oh[b[CTRL_IDX_LSB +: CTRL_IDX_W]] = 1'b1;
        end
        return oh;
    endfunction

    // Reset pin must stay low for the minimum pulse width
    icm_hold_filter #(.CYC(RST_PULSE_CYC)) u_pin_filt (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .level_in (~RESET_N_IN),
        .trip_out (rst_trip)
    );

    // Comparator output carries the hysteresis; short dips are ridden
    // through so a brief sag does not disturb an open channel
    icm_hold_filter #(.CYC(GLITCH_CYC)) u_por_filt (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .level_in (SUPPLY_LOW_IN),
        .trip_out (por_trip)
    );

    assign dev_rst = rst_trip | por_trip;

    // Bus conditions, taken from the previous line levels
    assign rise_w  = SCL_IN & ~r.scl_q;
    assign fall_w  = ~SCL_IN & r.scl_q;
    assign start_w = SCL_IN & r.scl_q & r.sda_q & ~SDA_IN;
    assign stop_w  = SCL_IN & r.scl_q & ~r.sda_q & SDA_IN;

    // Next-state logic of the serial slave and channel register
    always_comb begin
        n       = r;
        n.scl_q = SCL_IN;
        n.sda_q = SDA_IN;
        if (dev_rst) begin
            // Held in reset: all zero, silent, disconnected
            n = REGS_RESET;
            // Keep tracking the lines so release sees no false edge
            n.scl_q = SCL_IN;
            n.sda_q = SDA_IN;
        end else if (start_w) begin
            // Repeated START cancels an armed software reset
            n.st     = ST_ADDR;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
            n.gc_arm = 1'b0;
        end else if (stop_w) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
            if (r.gc_arm) begin
                n = REGS_RESET;
            end else if (r.pend_v) begin
                // Switch only now, when all lines are idle high
                n.ctrl   = r.pend;
                n.chan   = chan_decode(r.pend);
                n.pend_v = 1'b0;
            end
        end else begin
            case (r.st)
                // Collect address, then ack ours or the general call
                ST_ADDR: begin
                    if (rise_w) begin
                        n.sh  = {r.sh[6:0], SDA_IN};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall_w && r.cnt == BITS_PER_BYTE) begin
                        n.cnt = 4'h0;
                        if (r.sh[7:1] == SLAVE_ADDR_IN) begin
                            n.sda_oe = 1'b1;
                            n.st     = ST_ACK;
                            n.nxt    = r.sh[0] ? ST_RD : ST_WR;
                        end else if (r.sh == GC_ADDR_WR) begin
                            n.sda_oe = 1'b1;
                            n.st     = ST_ACK;
                            n.nxt    = ST_GC;
                        end else begin
                            n.st = ST_IGN;
                        end
                    end
                end
                // Acknowledge bit; release or start the read byte
                ST_ACK: begin
                    if (fall_w) begin
                        n.st     = r.nxt;
                        n.cnt    = 4'h0;
                        n.sda_oe = 1'b0;
                        if (r.nxt == ST_RD) begin
                            n.sh     = r.ctrl;
                            n.sda_oe = ~r.ctrl[7];
                            n.cnt    = 4'h1;
                        end
                    end
                end
                // Data byte; only the last before STOP is kept
                ST_WR: begin
                    if (rise_w) begin
                        n.sh  = {r.sh[6:0], SDA_IN};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall_w && r.cnt == BITS_PER_BYTE) begin
                        n.pend   = r.sh;
                        n.pend_v = 1'b1;
                        n.sda_oe = 1'b1;
                        n.st     = ST_ACK;
                        n.nxt    = ST_WR;
                        n.cnt    = 4'h0;
                    end
                end
                // Software reset code; any later byte goes unanswered
                ST_GC: begin
                    if (rise_w) begin
                        n.sh  = {r.sh[6:0], SDA_IN};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall_w && r.cnt == BITS_PER_BYTE) begin
                        n.cnt = 4'h0;
                        if (r.sh == SWRST_CODE) begin
                            n.sda_oe = 1'b1;
                            n.gc_arm = 1'b1;
                            n.st     = ST_ACK;
                            n.nxt    = ST_IGN;
                        end else begin
                            n.st = ST_IGN;
                        end
                    end
                end
                // Shift out the register, open-drain style
                ST_RD: begin
                    if (fall_w) begin
                        if (r.cnt == BITS_PER_BYTE) begin
                            n.sda_oe = 1'b0;
                            n.st     = ST_RDACK;
                        end else begin
                            n.sh     = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                            n.cnt    = r.cnt + 4'h1;
                        end
                    end
                end
                // Master ack repeats the byte, nack ends the read
                ST_RDACK: begin
                    if (rise_w && SDA_IN) begin
                        n.st = ST_IGN;
                    end else if (fall_w) begin
                        n.sh     = r.ctrl;
                        n.sda_oe = ~r.ctrl[7];
                        n.cnt    = 4'h1;
                        n.st     = ST_RD;
                    end
                end
                // Idle or not addressed: wait for START or STOP
                ST_IDLE, ST_IGN: begin
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.st     = ST_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r <= REGS_RESET;
        end else begin
            r <= n;
        end
    end

    // Open drain: only ever pulls low
    assign SDA_OUT     = 1'b0;
    assign SDA_OE_OUT  = r.sda_oe;
    assign CHAN_EN_OUT = r.chan;

    // Checks
    sequence s_stop_commit;
        stop_w && r.pend_v && !r.gc_arm && !dev_rst;
    endsequence

    sequence s_swrst_stop;
        stop_w && r.gc_arm && !dev_rst;
    endsequence

    property p_reset_silent;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        dev_rst |=> (!SDA_OE_OUT && CHAN_EN_OUT == 8'h00);
    endproperty
    a_reset_silent: assert property (p_reset_silent)
        else $error("Reset active but bus driven or channel on");

    property p_apply_at_stop;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_stop_commit |=> (CHAN_EN_OUT == chan_decode($past(r.pend)));
    endproperty
    a_apply_at_stop: assert property (p_apply_at_stop)
        else $error("Pending selection not applied at STOP");

    property p_hold_between_stops;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!stop_w && !dev_rst) |=> $stable(CHAN_EN_OUT);
    endproperty
    a_hold_between_stops: assert property (p_hold_between_stops)
        else $error("Channel changed without STOP");

    property p_onehot;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        $onehot0(CHAN_EN_OUT) && (CHAN_EN_OUT == chan_decode(r.ctrl));
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("Channel enables disagree with register");

    property p_last_byte_kept;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (r.st == ST_WR && fall_w && r.cnt == BITS_PER_BYTE && !dev_rst
            && !start_w && !stop_w) |=> (r.pend == $past(r.sh) && r.pend_v);
    endproperty
    a_last_byte_kept: assert property (p_last_byte_kept)
        else $error("Written byte not latched");

    property p_swrst;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        s_swrst_stop |=> (r.ctrl == CTRL_RESET && CHAN_EN_OUT == 8'h00);
    endproperty
    a_swrst: assert property (p_swrst)
        else $error("Software reset not performed at STOP");

    property p_pin_trip_cause;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        $rose(rst_trip) |-> $past(!RESET_N_IN, RST_PULSE_CYC)
            && !$past(RESET_N_IN);
    endproperty
    a_pin_trip_cause: assert property (p_pin_trip_cause)
        else $error("Reset pin tripped on a short pulse");

    property p_glitch_ignored;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        $rose(por_trip) |-> $past(SUPPLY_LOW_IN, GLITCH_CYC)
            && $past(SUPPLY_LOW_IN);
    endproperty
    a_glitch_ignored: assert property (p_glitch_ignored)
        else $error("Supply reset on a short glitch");

    property p_por_release;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!SUPPLY_LOW_IN ##1 !SUPPLY_LOW_IN) |-> !por_trip;
    endproperty
    a_por_release: assert property (p_por_release)
        else $error("Supply reset held after supply recovered");

    // Leaving a supply reset must find ctrl, the enables, the bus phase and the data drive at their zero state
    property p_por_zeroed;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        $fell(por_trip) |-> (r.ctrl == CTRL_RESET && CHAN_EN_OUT == 8'h00
            && r.st == ST_IDLE && !SDA_OE_OUT);
    endproperty
    a_por_zeroed: assert property (p_por_zeroed)
        else $error("Registers not zeroed at supply release");
endmodule
`default_nettype wire

// [tb/icm_tb_master.sv]
`default_nettype none
// Upstream bus master; the data line has a pull-up
module icm_tb_master (
    input  wire logic clk_in,    // System clock
    input  wire logic sda_oe_in, // Selector pulls data low
    output var  logic scl_out,   // Clock line
    output wire logic sda_out    // Resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_r; // Master data drive, 1 = released

    // Open drain: either party pulls low, else the pull-up wins
    assign sda_out = drv_r & ~sda_oe_in;

    // Idle bus at time zero
    initial begin
        scl_out = 1'b1;
        drv_r   = 1'b1;
    end

    // All changes land on falling edges, away from sampling
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // One bit slot; 4 cycles low, 4 high, data moves mid-low
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        drv_r = b;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        s = sda_out;
        tick(2);
        scl_out = 1'b0;
    endtask

    // Start or repeated start; leaves the clock low
    task automatic start();
        tick(2);
        drv_r = 1'b1;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        drv_r = 1'b0;
        tick(2);
        scl_out = 1'b0;
    endtask

    // Stop; leaves the bus idle
    task automatic stop();
        tick(2);
        drv_r = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        drv_r = 1'b1;
        tick(2);
    endtask

    // Byte out, MSB first, then sample the acknowledge
    task automatic byte_wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Byte in with the line released, then our own acknowledge
    task automatic byte_rd(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~mack, s);
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
// Self-checking bench for the channel selector
module tb_top
    import icm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h72;       // Strapped address
    localparam logic [7:0] WA  = {DEV, 1'b0}; // Write address byte
    localparam logic [7:0] RA  = {DEV, 1'b1}; // Read address byte
    logic       clk       = 1'b0; // 50 MHz clock
    logic       rst       = 1'b1; // Async reset
    logic       rst_pin_n = 1'b1; // Reset pin
    logic       sup_low   = 1'b0; // Supply comparator
    wire  logic scl;              // Bus clock
    wire  logic sda;              // Resolved bus data
    logic       sda_oe;           // Selector pulls data
    logic [7:0] chan;             // Pair enables
    logic       sda_drv;          // Selector drive level
    int         num_errors = 0;
    int         checked    = 0;

    icm_mux_ctrl uut (
        .CLK_SYS_IN    (clk),
        .RST_IN        (rst),
        .RESET_N_IN    (rst_pin_n),
        .SUPPLY_LOW_IN (sup_low),
        .SLAVE_ADDR_IN (DEV),
        .SCL_IN        (scl),
        .SDA_IN        (sda),
        .SDA_OUT       (sda_drv),
        .SDA_OE_OUT    (sda_oe),
        .CHAN_EN_OUT   (chan)
    );
    icm_tb_master m (
        .clk_in    (clk),
        .sda_oe_in (sda_oe),
        .scl_out   (scl),
        .sda_out   (sda)
    );

    // Free-running clock
    initial begin
        forever #10 clk = ~clk;
    end

    // Byte compare
    task automatic chk8(input logic [7:0] g, e, input string w);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask

    // Acknowledge compare
    task automatic chk1(input logic g, e, input string w);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s ack %b exp %b", $time, w, g, e);
        end
    endtask

    // Expected enables for a control byte; upper nibble ignored
    function automatic logic [7:0] dec(input logic [7:0] d);
        return d[CTRL_EN_POS] ? 8'h01 << d[2:0] : 8'h00;
    endfunction

    // Start, address byte, one data byte; no stop yet
    task automatic send(input logic [7:0] ab, d, input logic ea, ed);
        logic a;
        m.start();
        m.byte_wr(ab, a);
        chk1(a, ea, "addr");
        m.byte_wr(d, a);
        chk1(a, ed, "data");
    endtask

    // Two reads: master acks the first, refuses the second
    task automatic rd(input logic [7:0] e);
        logic       a;
        logic [7:0] d;
        m.start();
        m.byte_wr(RA, a);
        chk1(a, 1'b1, "read addr");
        m.byte_rd(1'b1, d);
        chk8(d, e, "read 1");
        m.byte_rd(1'b0, d);
        chk8(d, e, "read 2");
        chk1(sda_drv, 1'b0, "drive level");
        m.stop();
    endtask

    // Every enable/index code, with junk in the upper nibble
    task automatic t_table;
        logic [3:0] n;
        logic [7:0] d;
        logic [7:0] prev;
        prev = 8'h00;
        for (int i = 0; i < 16; i++) begin
            n = 4'(i);
            d = {~n, n};
            send(WA, d, 1'b1, 1'b1);
            chk8(chan, prev, "before stop");
            m.stop();
            chk8(chan, dec(d), "decode");
            rd(d);
            prev = dec(d);
        end
    endtask

    // Burst keeps the last byte; a foreign address is ignored
    task automatic t_burst;
        logic a;
        send(WA, 8'h09, 1'b1, 1'b1);
        m.byte_wr(8'h0E, a);
        chk1(a, 1'b1, "burst");
        m.stop();
        chk8(chan, dec(8'h0E), "last byte");
        send({~DEV, 1'b0}, 8'h08, 1'b0, 1'b0);
        m.stop();
        chk8(chan, dec(8'h0E), "foreign");
    endtask

    // General call: wrong code and read refused, 06h then stop
    task automatic t_gc;
        logic a;
        send(GC_ADDR_WR, 8'h05, 1'b1, 1'b0);
        m.stop();
        chk8(chan, dec(8'h0E), "bad code");
        m.start();
        m.byte_wr(GC_ADDR_WR | 8'h01, a);
        chk1(a, 1'b0, "gc read");
        m.stop();
        // Repeated START after the code cancels the reset
        send(GC_ADDR_WR, SWRST_CODE, 1'b1, 1'b1);
        send(WA, 8'h0B, 1'b1, 1'b1);
        m.stop();
        chk8(chan, dec(8'h0B), "restart cancels");
        send(GC_ADDR_WR, SWRST_CODE, 1'b1, 1'b1);
        m.stop();
        chk8(chan, 8'h00, "soft reset");
        rd(8'h00);
    endtask

    // Drive one reset source: pin (active low) or supply flag
    task automatic set_src(input bit pin, input logic v);
        if (pin) begin
            rst_pin_n = ~v;
        end else begin
            sup_low = v;
        end
    endtask

    // Short pulse rides through; a full one clears and mutes
    task automatic t_src(input bit pin, input int full);
        send(WA, 8'h0D, 1'b1, 1'b1);
        m.stop();
        set_src(pin, 1'b1);
        m.tick(full - 5);
        set_src(pin, 1'b0);
        m.tick(2);
        chk8(chan, dec(8'h0D), "short");
        set_src(pin, 1'b1);
        m.tick(full + 2);
        chk8(chan, 8'h00, "cleared");
        send(WA, 8'h0D, 1'b0, 1'b0);
        m.stop();
        chk8(chan, 8'h00, "held");
        set_src(pin, 1'b0);
        m.tick(2);
        rd(8'h00);
    endtask

    // Counts, verdict and end of run
    task automatic wrap_up;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        m.tick(2);
        chk8(chan, 8'h00, "power-up");
        rd(8'h00);
        t_table();
        t_burst();
        t_gc();
        t_src(1'b1, RST_PULSE_CYC);
        t_src(1'b0, GLITCH_CYC);
        wrap_up();
    end

    // Hang guard, about twice the expected run
    initial begin
        #400000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
